//--- include/ilpg_pkg.sv
package ilpg_pkg;

    // register byte offsets
    localparam logic [7:0] ILPG_OFS_FORMAT = 8'h00;
    localparam logic [7:0] ILPG_OFS_MFRAME = 8'h04;
    localparam logic [7:0] ILPG_OFS_DID = 8'h08;
    localparam logic [7:0] ILPG_OFS_CTRL = 8'h0C;
    localparam logic [7:0] ILPG_OFS_STATUS = 8'h10;

    // field positions
    localparam int ILPG_CTRL_SCR_BIT = 0;
    localparam int ILPG_ST_DES_BIT = 0;
    localparam int ILPG_ST_LM1_LSB = 8;
    localparam int ILPG_ST_CHK_LSB = 16;

    // reset values
    localparam logic [4:0] ILPG_RST_FORMAT = 5'h04;
    localparam logic [4:0] ILPG_RST_MFRAME = 5'h1F;
    localparam logic [7:0] ILPG_RST_DID = 8'h00;
    localparam logic ILPG_RST_SCR = 1'b0;

    // supported link format codes
    localparam logic [4:0] ILPG_FMT_S4 = 5'h04;
    localparam logic [4:0] ILPG_FMT_S8 = 5'h05;
    localparam logic [4:0] ILPG_FMT_D4 = 5'h06;
    localparam logic [4:0] ILPG_FMT_D8 = 5'h07;
    localparam logic [4:0] ILPG_FMT_S16 = 5'h11;
    localparam logic [4:0] ILPG_FMT_D16 = 5'h12;

    // frames per multiframe range and step
    localparam int ILPG_K_MIN = 18;
    localparam int ILPG_K_STEP = 2;
    localparam int ILPG_K_MAX = 32;

    // fixed parameter values, minus-one encoded where the link expects it
    localparam logic [7:0] ILPG_FM1 = 8'h00;
    localparam logic [7:0] ILPG_MM1 = 8'h00;
    localparam logic [4:0] ILPG_NM1 = 5'h07;
    localparam logic [4:0] ILPG_NPM1 = 5'h07;
    localparam logic [1:0] ILPG_CS = 2'h0;
    localparam logic [2:0] ILPG_JESDV = 3'h1;
    localparam logic [2:0] ILPG_SUBCV = 3'h1;
    localparam logic [3:0] ILPG_ADJCNT = 4'h0;
    localparam logic [3:0] ILPG_BID = 4'h0;
    localparam logic ILPG_ADJDIR = 1'b0;
    localparam logic ILPG_PHADJ = 1'b0;
    localparam logic ILPG_HD = 1'b0;
    localparam logic [4:0] ILPG_CF = 5'h00;
    localparam logic [7:0] ILPG_RES1 = 8'h00;
    localparam logic [7:0] ILPG_RES2 = 8'h00;

    // sequence geometry
    localparam logic [3:0] ILPG_LAST_IDX = 4'hD;
    localparam int ILPG_LANES_PER_LINK = 8;

    typedef enum logic [1:0]
    {
        ILPG_IDLE = 2'b00,
        ILPG_SEND = 2'b01
    } ilpg_state_e;

    typedef struct packed
    {
        logic ok;
        logic des;
        logic [4:0] lm1;
        logic [4:0] sm1;
    } ilpg_mode_s;

    typedef struct packed
    {
        logic [7:0] did;
        logic [4:0] lid;
        logic scr;
        logic [4:0] lm1;
        logic [4:0] mframe;
        logic [4:0] sm1;
    } ilpg_cfg_s;

    function automatic ilpg_mode_s ilpg_decode(input logic [4:0] fmt);
        ilpg_mode_s m;
        m = '0;
        case (fmt)
            ILPG_FMT_S4: m = '{1'b1, 1'b1, 5'h01, 5'h01};
            ILPG_FMT_S8: m = '{1'b1, 1'b1, 5'h03, 5'h03};
            ILPG_FMT_D4: m = '{1'b1, 1'b0, 5'h01, 5'h01};
            ILPG_FMT_D8: m = '{1'b1, 1'b0, 5'h03, 5'h03};
            ILPG_FMT_S16: m = '{1'b1, 1'b1, 5'h07, 5'h07};
            ILPG_FMT_D16: m = '{1'b1, 1'b0, 5'h07, 5'h07};
            default: m = '0;
        endcase
        return m;
    endfunction

    function automatic logic ilpg_mframe_ok(input logic [4:0] mframe);
        int k;
        k = int'(mframe) + 1;
        return (k >= ILPG_K_MIN) && (k <= ILPG_K_MAX) &&
               (((k - ILPG_K_MIN) % ILPG_K_STEP) == 0);
    endfunction

    function automatic logic [7:0] ilpg_chksum(input ilpg_cfg_s c);
        logic [7:0] s;
        s = c.did + {4'h0, ILPG_ADJCNT} + {4'h0, ILPG_BID};
        s = s + {7'h00, ILPG_ADJDIR} + {7'h00, ILPG_PHADJ};
        s = s + {3'h0, c.lid} + {7'h00, c.scr} + {3'h0, c.lm1};
        s = s + ILPG_FM1 + {3'h0, c.mframe} + ILPG_MM1;
        s = s + {6'h00, ILPG_CS} + {3'h0, ILPG_NM1};
        s = s + {5'h00, ILPG_SUBCV} + {3'h0, ILPG_NPM1};
        s = s + {5'h00, ILPG_JESDV} + {3'h0, c.sm1};
        s = s + {7'h00, ILPG_HD} + {3'h0, ILPG_CF};
        s = s + ILPG_RES1 + ILPG_RES2;
        return s;
    endfunction

    function automatic logic [7:0] ilpg_octet(input logic [3:0] idx,
                                              input ilpg_cfg_s c);
        logic [7:0] o;
        o = 8'h00;
        case (idx)
            4'h0: o = c.did;
            4'h1: o = {ILPG_ADJCNT, ILPG_BID};
            4'h2: o = {1'b0, ILPG_ADJDIR, ILPG_PHADJ, c.lid};
            4'h3: o = {c.scr, 2'h0, c.lm1};
            4'h4: o = ILPG_FM1;
            4'h5: o = {3'h0, c.mframe};
            4'h6: o = ILPG_MM1;
            4'h7: o = {ILPG_CS, 1'b0, ILPG_NM1};
            4'h8: o = {ILPG_SUBCV, ILPG_NPM1};
            4'h9: o = {ILPG_JESDV, c.sm1};
            4'hA: o = {ILPG_HD, 2'h0, ILPG_CF};
            4'hB: o = ILPG_RES1;
            4'hC: o = ILPG_RES2;
            4'hD: o = ilpg_chksum(c);
            default: o = 8'h00;
        endcase
        return o;
    endfunction

endpackage

//--- logic/ilpg_top.sv
// Summary of operation
// - send every link parameter during alignment
// - derive non-user parameters from format select
// - adjustment amount field always zero
// - adjustment direction field always zero
// - bank, control words, reserved fields zero
// - control bits per sample reported zero
// - device identifier from user register
// - high-density flag always zero
// - frames per multiframe from register, checked
// - lanes, samples from mode; octets, resolution fixed
// - bits per sample includes control, tail
// - report converter count for packing only
// - lane identifier derived, not user set
// - scrambler field from control register bit
// - checksum is field sum modulo 256
// - only codes 4-7, 17, 18 accepted
// - second link sends identifier plus one
//
// The implementer's own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps

module ilpg_top
    import ilpg_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    // clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // register bus
    input wire logic [ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // alignment parameter request from link logic
    input wire logic ILAS_REQ,
    input wire logic ILAS_LINK,
    input wire logic [2:0] ILAS_LANE,
    // alignment parameter octet stream
    output logic ILAS_BUSY,
    output logic ILAS_VALID,
    output logic [7:0] ILAS_OCTET,
    output logic [3:0] ILAS_INDEX,
    output logic ILAS_LAST,
    // derived lane usage
    output logic SINGLE_CHANNEL,
    output logic [15:0] LANE_ENABLE
);

    typedef struct packed
    {
        logic [4:0] fmt;
        logic [4:0] mframe;
        logic [7:0] did;
        logic scr;
        logic ack;
        logic [31:0] rdata;
        ilpg_state_e st;
        ilpg_cfg_s snap;
        logic [3:0] idx;
        logic valid;
        logic [7:0] octet;
        logic [3:0] oidx;
        logic last;
        logic des;
        logic [15:0] lane_en;
    } ilpg_regs_s;

    ilpg_regs_s s_r;
    ilpg_regs_s s_nxt;

    ilpg_mode_s mode;
    ilpg_cfg_s cfg0;
    logic req;
    logic [7:0] ofs;
    logic [4:0] new_fmt;
    logic [4:0] new_mframe;
    logic [7:0] link_en;

    assign req = AVS_READ | AVS_WRITE;
    assign ofs = 8'(AVS_ADDRESS);
    assign AVS_WAITREQUEST = req & ~s_r.ack;
    assign AVS_READDATA = s_r.rdata;

    assign ILAS_BUSY = (s_r.st != ILPG_IDLE);
    assign ILAS_VALID = s_r.valid;
    assign ILAS_OCTET = s_r.octet;
    assign ILAS_INDEX = s_r.oidx;
    assign ILAS_LAST = s_r.last;
    assign SINGLE_CHANNEL = s_r.des;
    assign LANE_ENABLE = s_r.lane_en;

    assign new_fmt = AVS_WRITEDATA[4:0];
    assign new_mframe = AVS_WRITEDATA[4:0];

    assign mode = ilpg_decode(s_r.fmt);

    // link 0, lane 0 view for the status readback
    always_comb
    begin
        cfg0 = '0;
        cfg0.did = s_r.did;
        cfg0.lid = 5'h00;
        cfg0.scr = s_r.scr;
        cfg0.lm1 = mode.lm1;
        cfg0.mframe = s_r.mframe;
        cfg0.sm1 = mode.sm1;
    end

    // lowest lanes of each link in use, upper ones powered down
    always_comb
    begin
        link_en = '0;
        for (int i = 0; i < ILPG_LANES_PER_LINK; i++)
        begin
            link_en[i] = mode.ok && (i <= int'(mode.lm1));
        end
    end

    always_comb
    begin
        s_nxt = s_r;

        // one wait cycle per access, then the answer
        s_nxt.ack = req & ~s_r.ack;
        if (AVS_READ && !s_r.ack)
        begin
            s_nxt.rdata = 32'h0000_0000;
            case (ofs)
                ILPG_OFS_FORMAT: s_nxt.rdata[4:0] = s_r.fmt;
                ILPG_OFS_MFRAME: s_nxt.rdata[4:0] = s_r.mframe;
                ILPG_OFS_DID: s_nxt.rdata[7:0] = s_r.did;
                ILPG_OFS_CTRL: s_nxt.rdata[ILPG_CTRL_SCR_BIT] = s_r.scr;
                ILPG_OFS_STATUS:
                begin
                    s_nxt.rdata[ILPG_ST_DES_BIT] = mode.des;
                    s_nxt.rdata[ILPG_ST_LM1_LSB +: 5] = mode.lm1;
                    s_nxt.rdata[ILPG_ST_CHK_LSB +: 8] = ilpg_chksum(cfg0);
                end
                default: s_nxt.rdata = 32'h0000_0000;
            endcase
        end

        if (AVS_WRITE && s_r.ack && AVS_BYTEENABLE[0])
        begin
            case (ofs)
                ILPG_OFS_FORMAT:
                begin
                    if (ilpg_decode(new_fmt).ok)
                    begin
                        s_nxt.fmt = new_fmt;
                    end
                end
                ILPG_OFS_MFRAME:
                begin
                    if (ilpg_mframe_ok(new_mframe))
                    begin
                        s_nxt.mframe = new_mframe;
                    end
                end
                ILPG_OFS_DID: s_nxt.did = AVS_WRITEDATA[7:0];
                ILPG_OFS_CTRL: s_nxt.scr = AVS_WRITEDATA[ILPG_CTRL_SCR_BIT];
                default: s_nxt.fmt = s_r.fmt;
            endcase
        end

        s_nxt.des = mode.des;
        s_nxt.lane_en = {link_en, link_en};

        s_nxt.valid = 1'b0;
        s_nxt.last = 1'b0;
        case (s_r.st)
            ILPG_IDLE:
            begin
                // lanes beyond the link width are refused
                if (ILAS_REQ && mode.ok && ({2'b00, ILAS_LANE} <= mode.lm1))
                begin
                    s_nxt.st = ILPG_SEND;
                    s_nxt.idx = 4'h0;
                    s_nxt.snap.did = s_r.did + {7'h00, ILAS_LINK};
                    s_nxt.snap.lid = {2'b00, ILAS_LANE};
                    s_nxt.snap.scr = s_r.scr;
                    s_nxt.snap.lm1 = mode.lm1;
                    s_nxt.snap.mframe = s_r.mframe;
                    s_nxt.snap.sm1 = mode.sm1;
                end
            end
            ILPG_SEND:
            begin
                s_nxt.octet = ilpg_octet(s_r.idx, s_r.snap);
                s_nxt.oidx = s_r.idx;
                s_nxt.valid = 1'b1;
                s_nxt.idx = s_r.idx + 4'h1;
                if (s_r.idx == ILPG_LAST_IDX)
                begin
                    s_nxt.last = 1'b1;
                    s_nxt.st = ILPG_IDLE;
                end
            end
            default: s_nxt.st = ILPG_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            s_r <= '0;
            s_r.fmt <= ILPG_RST_FORMAT;
            s_r.mframe <= ILPG_RST_MFRAME;
            s_r.did <= ILPG_RST_DID;
            s_r.scr <= ILPG_RST_SCR;
            s_r.st <= ILPG_IDLE;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

endmodule

//--- test/ilpg_properties.sv
`timescale 1ns/10ps
module ilpg_properties
(
    // clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // request side
    input wire logic ILAS_REQ,
    input wire logic [2:0] ILAS_LANE,
    input wire logic ILAS_BUSY,
    input wire logic [15:0] LANE_ENABLE,
    // octet stream
    input wire logic ILAS_VALID,
    input wire logic [7:0] ILAS_OCTET,
    input wire logic [3:0] ILAS_INDEX,
    input wire logic ILAS_LAST
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);
    logic take;
    logic v;
    assign take = ILAS_REQ && !ILAS_BUSY && LANE_ENABLE[ILAS_LANE];
    assign v = ILAS_VALID;

    a_seq_length: assert property (v && ILAS_INDEX == 4'h0 |->
        (v && !ILAS_LAST) [*8] ##6 (ILAS_LAST && ILAS_INDEX == 4'hD))
        else $error("sequence not 14 octets");
    a_adj_zero: assert property (v && ILAS_INDEX == 4'h1 |->
        ILAS_OCTET == 8'h00) else $error("adjust or bank not zero");
    a_dir_zero: assert property (v && ILAS_INDEX == 4'h2 |->
        ILAS_OCTET[7:5] == 3'h0) else $error("adjust direction not zero");
    a_res_zero: assert property (v && ILAS_INDEX inside {4'hA, 4'hB,
        4'hC} |-> ILAS_OCTET == 8'h00) else $error("reserved field set");
    a_cs_zero: assert property (v && ILAS_INDEX == 4'h7 |->
        ILAS_OCTET[7:5] == 3'h0) else $error("control bits not zero");
    a_rev_one: assert property (v && ILAS_INDEX == 4'h8 |->
        ILAS_OCTET[7:5] == 3'h1 ##1 ILAS_OCTET[7:5] == 3'h1)
        else $error("revision fields not one");
    a_lid_lane: assert property (take |-> ##2 (v && ILAS_INDEX == 4'h0)
        ##2 ILAS_OCTET[4:0] == {2'b00, $past(ILAS_LANE, 4)})
        else $error("lane identifier mismatch");
    a_samples_lanes: assert property (v && ILAS_INDEX == 4'h9 |->
        ((ILAS_OCTET ^ $past(ILAS_OCTET, 6)) & 8'h1F) == 8'h00)
        else $error("samples differ from lanes");
    a_busy_stream: assert property (v && !ILAS_LAST |-> ILAS_BUSY)
        else $error("busy low inside a sequence");

    c_last: cover property (ILAS_LAST);
    c_top_lane: cover property (take && ILAS_LANE == 3'h7);
    c_refused: cover property (ILAS_REQ && !ILAS_BUSY && !take);
endmodule

//--- test/ilpg_rx_model.sv
`timescale 1ns/10ps
module ilpg_rx_model
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // bench side
    input wire logic go,
    input wire logic link,
    input wire logic [2:0] lane,
    output logic [13:0][7:0] cap,
    output logic got,
    // alignment stream
    output logic req,
    output logic req_link,
    output logic [2:0] req_lane,
    input wire logic valid,
    input wire logic [7:0] octet,
    input wire logic [3:0] index,
    input wire logic last
);
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            req <= 1'b0;
            req_link <= 1'b0;
            req_lane <= 3'h0;
            got <= 1'b0;
            cap <= '0;
        end
        else
        begin
            req <= go;
            if (go)
            begin
                req_link <= link;
                req_lane <= lane;
                got <= 1'b0;
            end
            if (valid)
                cap[index] <= octet;
            if (valid && last)
                got <= 1'b1;
        end
    end
endmodule

//--- test/ilas_parameter_generator_tb.sv
`timescale 1ns/10ps
module ilas_parameter_generator_tb import ilpg_pkg::*;;
    localparam logic [31:0] RV [6] = '{32'h04, 32'h1F, 32'h00, 32'h00,
        32'h00310101, 32'h00};
    // format, single-channel flag, lanes minus one
    localparam logic [15:0] FT [8] = '{16'h0411, 16'h0513, 16'h0813,
        16'h0601, 16'h0703, 16'h1003, 16'h1117, 16'h1207};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [3:0] be = 4'hF;
    logic go = 1'b0;
    logic lk = 1'b0;
    logic [2:0] ln = 3'h0;
    logic [31:0] rdat, q;
    logic ws, req, rlk, busy, vld, last, single, got;
    logic [2:0] rln;
    logic [7:0] oct, m;
    logic [3:0] idx;
    logic [15:0] lane_en;
    logic [13:0][7:0] cap;
    int n_mismatch = 0;
    int checks_done = 0;

    always #50 clk = ~clk;

    ilpg_top uut
    (
        .CLK(clk), .RESET_N(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be),
        .AVS_READDATA(rdat), .AVS_WAITREQUEST(ws), .ILAS_REQ(req),
        .ILAS_LINK(rlk), .ILAS_LANE(rln), .ILAS_BUSY(busy),
        .ILAS_VALID(vld), .ILAS_OCTET(oct), .ILAS_INDEX(idx),
        .ILAS_LAST(last), .SINGLE_CHANNEL(single), .LANE_ENABLE(lane_en)
    );

    ilpg_rx_model rx
    (
        .clk(clk), .rst_n(rst_n), .go(go), .link(lk), .lane(ln),
        .cap(cap), .got(got), .req(req), .req_link(rlk), .req_lane(rln),
        .valid(vld), .octet(oct), .index(idx), .last(last)
    );

    task automatic test_done;
        if (n_mismatch == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] b);
        int n;
        n = 0;
        adr <= a;
        wd <= d;
        be <= b;
        wr <= w;
        rd <= !w;
        // waitrequest and read data taken at the same rising edge
        do
        begin
            @(posedge clk);
            n++;
        end while (ws !== 1'b0 && n < 20);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        if (n >= 20)
        begin
            n_mismatch++;
            test_done();
        end
        @(posedge clk);
    endtask

    task automatic ask(input logic l, input logic [2:0] n, input logic want);
        int t;
        t = 0;
        go <= 1'b1;
        lk <= l;
        ln <= n;
        @(posedge clk);
        go <= 1'b0;
        // extra edge so the model has cleared its done flag
        @(posedge clk);
        while (got !== 1'b1 && t < 30)
        begin
            @(posedge clk);
            t++;
        end
        chk({31'h0, got}, {31'h0, want});
        if (want && t >= 30)
            test_done();
    endtask

    task automatic seq(input logic l, input logic [2:0] n, input logic [7:0] d,
                       input logic s, input logic [4:0] k, input logic [4:0] g);
        logic [13:0][7:0] e;
        e = '0;
        e[0] = d + {7'h00, l};
        e[2] = {5'h00, n};
        e[3] = {s, 2'h0, k};
        e[5] = {3'h0, g};
        e[7] = 8'h07;
        e[8] = 8'h27;
        e[9] = {3'h1, k};
        e[13] = e[0] + e[2] + {7'h00, s} + {3'h0, k} + e[5] + 8'h10 + e[3][4:0];
        ask(l, n, 1'b1);
        for (int i = 0; i < 14; i++)
            chk({24'h0, cap[i]}, {24'h0, e[i]});
    endtask

    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 6; i++)
        begin
            bus(1'b0, 8'(4 * i), 32'h0, 4'hF);
            chk(q, RV[i]);
        end
        seq(1'b0, 3'h1, 8'h00, 1'b0, 5'h01, 5'h1F);
        ask(1'b0, 3'h2, 1'b0);
        bus(1'b1, ILPG_OFS_DID, 32'hA5, 4'hF);
        bus(1'b1, ILPG_OFS_DID, 32'h3C, 4'hE);
        bus(1'b1, ILPG_OFS_CTRL, 32'h1, 4'hF);
        bus(1'b1, ILPG_OFS_MFRAME, 32'h11, 4'hF);
        bus(1'b1, ILPG_OFS_MFRAME, 32'h12, 4'hF);
        bus(1'b0, ILPG_OFS_MFRAME, 32'h0, 4'hF);
        chk(q, 32'h11);
        bus(1'b0, ILPG_OFS_DID, 32'h0, 4'hF);
        chk(q, 32'hA5);
        for (int i = 0; i < 8; i++)
        begin
            bus(1'b1, ILPG_OFS_FORMAT, {24'h0, FT[i][15:8]}, 4'hF);
            bus(1'b0, ILPG_OFS_STATUS, 32'h0, 4'hF);
            m = 8'hFF >> (3'h7 - FT[i][2:0]);
            chk(q & 32'h1F01, {20'h0, FT[i][3:0], 7'h0, FT[i][4]});
            chk({16'h0, lane_en}, {16'h0, m, m});
            chk({31'h0, single}, {31'h0, FT[i][4]});
        end
        seq(1'b1, 3'h7, 8'hA5, 1'b1, 5'h07, 5'h11);
        test_done();
    end
endmodule

bind ilpg_top ilpg_properties u_props
(
    .CLK(CLK), .RESET_N(RESET_N), .ILAS_REQ(ILAS_REQ),
    .ILAS_LANE(ILAS_LANE), .ILAS_BUSY(ILAS_BUSY),
    .LANE_ENABLE(LANE_ENABLE), .ILAS_VALID(ILAS_VALID),
    .ILAS_OCTET(ILAS_OCTET), .ILAS_INDEX(ILAS_INDEX), .ILAS_LAST(ILAS_LAST)
);
